// ---- include/ela_pkg.sv ----
// Purpose: shared constants and types for the embedded trigger analyzer
// Assumes: 50 MHz sample clock, widths fixed at build
// Notes: pattern codes take 3 bits per trigger bit
package ela_pkg;
    localparam int EDGE_N = 8;
    localparam int LEVEL_N = 8;
    localparam int TRIG_W = EDGE_N + LEVEL_N;
    localparam int TRACE_W = 16;
    localparam int DEPTH = 512;
    localparam int ADDR_W = $clog2(DEPTH);
    localparam int CNT_W = 16;
    localparam logic [2:0] PAT_ZERO = 3'h0;
    localparam logic [2:0] PAT_ONE = 3'h1;
    localparam logic [2:0] PAT_RISE = 3'h2;
    localparam logic [2:0] PAT_FALL = 3'h3;
    localparam logic [2:0] PAT_BOTH = 3'h4;
    localparam logic [2:0] PAT_DONT = 3'h5;
    localparam logic [2:0] CMP_EQ = 3'h0;
    localparam logic [2:0] CMP_NE = 3'h1;
    localparam logic [2:0] CMP_GT = 3'h2;
    localparam logic [2:0] CMP_LT = 3'h3;
    localparam logic [2:0] CMP_LE = 3'h4;
    localparam logic [2:0] CMP_GE = 3'h5;
    localparam logic [1:0] COND_A = 2'h0;
    localparam logic [1:0] COND_AB = 2'h1;
    localparam logic [1:0] COND_B_THEN_A = 2'h2;
    localparam logic [1:0] POS_CUSTOM = 2'h0;
    localparam logic [1:0] POS_PRE = 2'h1;
    localparam logic [1:0] POS_CENTER = 2'h2;
    localparam logic [1:0] POS_POST = 2'h3;
    localparam logic [ADDR_W-1:0] POST_PRE = ADDR_W'(DEPTH * 95 / 100);
    localparam logic [ADDR_W-1:0] POST_CENTER = ADDR_W'(DEPTH * 50 / 100);
    localparam logic [ADDR_W-1:0] POST_POST = ADDR_W'(DEPTH * 5 / 100);
    localparam logic [1:0] TOUT_NONE = 2'h0;
    localparam logic [1:0] TOUT_PIN = 2'h1;
    localparam logic [1:0] TOUT_CHAIN = 2'h2;
    typedef enum logic [2:0] {ST_IDLE, ST_FILL, ST_WAIT, ST_POST, ST_DONE} cap_state_t;
endpackage

// ---- logic/event_matcher.sv ----
`timescale 1ns/1ns
// Purpose: pattern match and occurrence counting for one event
// Assumes: bus and prev_bus both on the sample clock
// Notes: event stays true until clr
module event_matcher #(
    parameter bit HAS_MAG = 1'h1,
    parameter bit HAS_CNT = 1'h1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic enable,
    input wire logic [ela_pkg::TRIG_W-1:0] bus,
    input wire logic [ela_pkg::TRIG_W-1:0] prev_bus,
    input wire logic [3*ela_pkg::TRIG_W-1:0] codes,
    input wire logic [2:0] op,
    input wire logic [ela_pkg::CNT_W-1:0] count_n,
    output logic hit,
    output logic event_o
);
    localparam int W = ela_pkg::TRIG_W;
    localparam int CW = ela_pkg::CNT_W;

    // level bits see edge codes as don't care
    function automatic logic bit_ok(input logic [2:0] c, input logic cur,
                                    input logic prv, input logic is_edge);
        logic ok;
        ok = 1'h1;
        case (c)
            ela_pkg::PAT_ZERO: ok = !cur;
            ela_pkg::PAT_ONE: ok = cur;
            ela_pkg::PAT_RISE: ok = !is_edge || (cur && !prv);
            ela_pkg::PAT_FALL: ok = !is_edge || (!cur && prv);
            ela_pkg::PAT_BOTH: ok = !is_edge || (cur != prv);
            default: ok = 1'h1;
        endcase
        return ok;
    endfunction

    logic [W-1:0] bit_match;
    logic [W-1:0] care;
    logic [W-1:0] val;
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign bit_match[i] = bit_ok(codes[3*i +: 3], bus[i], prev_bus[i], i < ela_pkg::EDGE_N);
        assign care[i] = codes[3*i +: 3] == ela_pkg::PAT_ZERO || codes[3*i +: 3] == ela_pkg::PAT_ONE;
        assign val[i] = codes[3*i +: 3] == ela_pkg::PAT_ONE;
    end

    wire all_eq = &bit_match;
    wire [W-1:0] masked = bus & care;
    logic mag;
    always_comb begin
        case (op)
            ela_pkg::CMP_NE: mag = masked != val;
            ela_pkg::CMP_GT: mag = masked > val;
            ela_pkg::CMP_LT: mag = masked < val;
            ela_pkg::CMP_LE: mag = masked <= val;
            ela_pkg::CMP_GE: mag = masked >= val;
            default: mag = all_eq;
        endcase
    end
    assign hit = (HAS_MAG && op != ela_pkg::CMP_EQ) ? mag : all_eq;

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic event_reg;
    logic event_next;
    wire [CW-1:0] n_eff = (!HAS_CNT || count_n == '0) ? CW'(1) : count_n;
    wire bump = enable && hit && !event_reg;
    assign cnt_next = clr ? '0 : (bump ? cnt_reg + 1'h1 : cnt_reg);
    assign event_next = clr ? 1'h0 : (event_reg || (bump && cnt_reg + 1'h1 == n_eff));
    assign event_o = event_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            event_reg <= 1'h0;
        end else begin
            cnt_reg <= cnt_next;
            event_reg <= event_next;
        end
    end

    event_count_a: assert property (@(posedge clk) disable iff (rst)
        $rose(event_reg) |-> $past(hit) && $past(enable) && $past(cnt_reg) + 1'h1 == $past(n_eff))
        else $error("event set before its match count");
endmodule

// ---- logic/link_port.sv ----
`timescale 1ns/1ns
// Purpose: link-side readout on the link clock
// Assumes: link pins are synchronous to link_clk
// Notes: words cross by toggle handshake, the word held stable
module link_port (
    input wire logic link_clk,
    input wire logic rst,
    input wire logic link_arm,
    input wire logic link_load,
    input wire logic link_shift,
    input wire logic done_lvl,
    input wire logic rd_ack_tgl,
    input wire logic [ela_pkg::TRACE_W-1:0] rd_word,
    output logic arm_tgl,
    output logic rd_req_tgl,
    output logic [ela_pkg::ADDR_W-1:0] rd_idx,
    output logic link_tdo,
    output logic link_word_ready,
    output logic link_done
);
    logic done_s1, done_s2, ack_s1, ack_s2, ack_seen_reg, ready_reg;
    logic arm_reg, req_reg;
    logic [ela_pkg::ADDR_W-1:0] idx_reg;
    logic [ela_pkg::TRACE_W-1:0] shift_reg;
    wire pending = req_reg != ack_seen_reg;
    wire ack_new = ack_s2 != ack_seen_reg;

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            done_s1 <= 1'h0;
            done_s2 <= 1'h0;
            ack_s1 <= 1'h0;
            ack_s2 <= 1'h0;
            ack_seen_reg <= 1'h0;
            ready_reg <= 1'h0;
            arm_reg <= 1'h0;
            req_reg <= 1'h0;
            idx_reg <= '0;
            shift_reg <= '0;
        end else begin
            done_s1 <= done_lvl;
            done_s2 <= done_s1;
            ack_s1 <= rd_ack_tgl;
            ack_s2 <= ack_s1;
            if (link_arm) begin
                arm_reg <= !arm_reg;
                idx_reg <= '0;
            end else if (ack_new) begin
                idx_reg <= idx_reg + 1'h1;
            end
            if (link_load && !pending) begin
                req_reg <= !req_reg;
                ready_reg <= 1'h0;
            end else if (ack_new) begin
                ack_seen_reg <= ack_s2;
                ready_reg <= 1'h1;
            end
            if (ack_new) begin
                shift_reg <= rd_word;
            end else if (link_shift) begin
                shift_reg <= {1'h0, shift_reg[ela_pkg::TRACE_W-1:1]};
            end
        end
    end

    assign arm_tgl = arm_reg;
    assign rd_req_tgl = req_reg;
    assign rd_idx = idx_reg;
    assign link_tdo = shift_reg[0];
    assign link_word_ready = ready_reg;
    assign link_done = done_s2;
endmodule

// ---- logic/ela_core.sv ----
`timescale 1ns/1ns
// Purpose: embedded logic analyzer trigger and trace capture
// Assumes: trig_bus and trace_bus on ref_clk; host on link_clk
// Notes: hold configuration ports steady while a capture runs
module ela_core #(
    parameter bit HAS_TRIG_IN = 1'h1,
    parameter logic [1:0] TRIG_OUT_MODE = 2'h1,
    parameter bit HAS_MAG = 1'h1,
    parameter bit HAS_CNT = 1'h1,
    parameter bit HAS_SAT = 1'h1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic [ela_pkg::TRIG_W-1:0] trig_bus,
    input wire logic [ela_pkg::TRACE_W-1:0] trace_bus,
    input wire logic trig_in_pin,
    input wire logic trig_in_en,
    input wire logic trig_in_pol,
    input wire logic trig_out_pol,
    input wire logic [3*ela_pkg::TRIG_W-1:0] pat_a_code,
    input wire logic [3*ela_pkg::TRIG_W-1:0] pat_b_code,
    input wire logic [2:0] cmp_op_a,
    input wire logic [2:0] cmp_op_b,
    input wire logic [ela_pkg::CNT_W-1:0] count_a,
    input wire logic [ela_pkg::CNT_W-1:0] count_b,
    input wire logic [1:0] cond_sel,
    input wire logic [1:0] pos_sel,
    input wire logic [ela_pkg::ADDR_W-1:0] post_len,
    input wire logic repeat_mode,
    input wire logic link_arm,
    input wire logic link_load,
    input wire logic link_shift,
    output logic link_tdo,
    output logic link_word_ready,
    output logic link_done,
    output logic trig_out_pin,
    output logic chain_trig_out,
    output logic capture_busy,
    output logic triggered
);
    localparam int AW = ela_pkg::ADDR_W;

    // link side, second clock domain
    logic arm_tgl, rd_req_tgl;
    logic [AW-1:0] rd_idx;
    logic done_reg, ack_tgl_reg;
    logic [ela_pkg::TRACE_W-1:0] rd_data_reg;

    link_port u_link (
        .link_clk(link_clk),
        .rst(rst),
        .link_arm(link_arm),
        .link_load(link_load),
        .link_shift(link_shift),
        .done_lvl(done_reg),
        .rd_ack_tgl(ack_tgl_reg),
        .rd_word(rd_data_reg),
        .arm_tgl(arm_tgl),
        .rd_req_tgl(rd_req_tgl),
        .rd_idx(rd_idx),
        .link_tdo(link_tdo),
        .link_word_ready(link_word_ready),
        .link_done(link_done)
    );

    // toggles into ref_clk; third stage only feeds the edge detect
    logic arm_s1, arm_s2, arm_s3, req_s1, req_s2, req_s3;
    logic tin_s1, tin_s2;
    wire arm_pulse = arm_s2 ^ arm_s3;
    wire rd_pulse = req_s2 ^ req_s3;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            arm_s1 <= 1'h0;
            arm_s2 <= 1'h0;
            arm_s3 <= 1'h0;
            req_s1 <= 1'h0;
            req_s2 <= 1'h0;
            req_s3 <= 1'h0;
            tin_s1 <= 1'h0;
            tin_s2 <= 1'h0;
        end else begin
            arm_s1 <= arm_tgl;
            arm_s2 <= arm_s1;
            arm_s3 <= arm_s2;
            req_s1 <= rd_req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            tin_s1 <= trig_in_pin;
            tin_s2 <= tin_s1;
        end
    end

    // external trigger, removed entirely when not built
    wire ext_act = HAS_TRIG_IN && trig_in_en && (tin_s2 == trig_in_pol);

    // previous sample for edge codes
    logic [ela_pkg::TRIG_W-1:0] prev_bus_reg;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_bus_reg <= '0;
        end else begin
            prev_bus_reg <= trig_bus;
        end
    end

    ela_pkg::cap_state_t state_reg, state_next;
    logic ev_a, ev_b, hit_a, hit_b;
    wire repeat_eff = HAS_SAT && repeat_mode;
    wire restart = state_reg == ela_pkg::ST_DONE && repeat_eff && rd_pulse
        && rd_idx == AW'(ela_pkg::DEPTH - 1);
    wire ev_clr = arm_pulse || restart;
    wire in_wait = state_reg == ela_pkg::ST_WAIT;
    // in the sequence mode the first event only counts once the second holds
    wire en_a = in_wait && (cond_sel != ela_pkg::COND_B_THEN_A || ev_b);

    event_matcher #(.HAS_MAG(HAS_MAG), .HAS_CNT(HAS_CNT)) u_ev_a (
        .clk(ref_clk),
        .rst(rst),
        .clr(ev_clr),
        .enable(en_a),
        .bus(trig_bus),
        .prev_bus(prev_bus_reg),
        .codes(pat_a_code),
        .op(cmp_op_a),
        .count_n(count_a),
        .hit(hit_a),
        .event_o(ev_a)
    );

    event_matcher #(.HAS_MAG(HAS_MAG), .HAS_CNT(HAS_CNT)) u_ev_b (
        .clk(ref_clk),
        .rst(rst),
        .clr(ev_clr),
        .enable(in_wait),
        .bus(trig_bus),
        .prev_bus(prev_bus_reg),
        .codes(pat_b_code),
        .op(cmp_op_b),
        .count_n(count_b),
        .hit(hit_b),
        .event_o(ev_b)
    );

    // trigger condition
    wire cond_met = (cond_sel == ela_pkg::COND_AB) ? (ev_a && ev_b) : ev_a;
    wire fire = in_wait && !arm_pulse && (cond_met || ext_act);

    // trigger position, latched at arm
    logic [AW-1:0] post_sel, post_cfg_reg, post_left_reg, fill_cnt_reg;
    always_comb begin
        case (pos_sel)
            ela_pkg::POS_PRE: post_sel = ela_pkg::POST_PRE;
            ela_pkg::POS_CENTER: post_sel = ela_pkg::POST_CENTER;
            ela_pkg::POS_POST: post_sel = ela_pkg::POST_POST;
            default: post_sel = post_len;
        endcase
    end
    wire [AW-1:0] pre_need = AW'(ela_pkg::DEPTH - 1) - post_cfg_reg;
    wire fill_done = {1'h0, fill_cnt_reg} + 1'h1 >= {1'h0, pre_need};

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ela_pkg::ST_IDLE: state_next = ela_pkg::ST_IDLE;
            ela_pkg::ST_FILL: begin
                if (fill_done) begin
                    state_next = ela_pkg::ST_WAIT;
                end
            end
            ela_pkg::ST_WAIT: begin
                if (fire) begin
                    state_next = (post_cfg_reg == '0) ? ela_pkg::ST_DONE : ela_pkg::ST_POST;
                end
            end
            ela_pkg::ST_POST: begin
                if (post_left_reg == AW'(1)) begin
                    state_next = ela_pkg::ST_DONE;
                end
            end
            ela_pkg::ST_DONE: begin
                if (restart) begin
                    state_next = ela_pkg::ST_FILL;
                end
            end
            default: state_next = ela_pkg::ST_IDLE;
        endcase
        if (arm_pulse) begin
            state_next = ela_pkg::ST_FILL;
        end
    end

    // trace memory, circular
    logic [ela_pkg::TRACE_W-1:0] mem [ela_pkg::DEPTH];
    logic [AW-1:0] wr_ptr_reg, trig_addr_reg;
    wire wr_en = state_reg == ela_pkg::ST_FILL || in_wait
        || state_reg == ela_pkg::ST_POST;
    wire [AW-1:0] rd_addr = trig_addr_reg - pre_need + rd_idx;

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_ptr_reg] <= trace_bus;
        end
    end

    logic hit_reg, hit_next, tout_pin_reg, tout_chain_reg;
    assign hit_next = ev_clr ? 1'h0 : (hit_reg || fire);
    wire tout_level = hit_next ? trig_out_pol : !trig_out_pol;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ela_pkg::ST_IDLE;
            wr_ptr_reg <= '0;
            trig_addr_reg <= '0;
            post_cfg_reg <= '0;
            post_left_reg <= '0;
            fill_cnt_reg <= '0;
            hit_reg <= 1'h0;
            done_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
            hit_reg <= hit_next;
            done_reg <= state_next == ela_pkg::ST_DONE;
            if (wr_en) begin
                wr_ptr_reg <= wr_ptr_reg + 1'h1;
            end
            if (arm_pulse) begin
                post_cfg_reg <= post_sel;
            end
            if (ev_clr) begin
                fill_cnt_reg <= '0;
            end else if (state_reg == ela_pkg::ST_FILL) begin
                fill_cnt_reg <= fill_cnt_reg + 1'h1;
            end
            if (fire) begin
                trig_addr_reg <= wr_ptr_reg;
                post_left_reg <= post_cfg_reg;
            end else if (state_reg == ela_pkg::ST_POST) begin
                post_left_reg <= post_left_reg - 1'h1;
            end
        end
    end

    // readout answer; data is stable before the ack toggle arrives
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= '0;
            ack_tgl_reg <= 1'h0;
        end else if (rd_pulse) begin
            rd_data_reg <= mem[rd_addr];
            ack_tgl_reg <= !ack_tgl_reg;
        end
    end

    // trigger outputs, inactive low when not built
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tout_pin_reg <= 1'h0;
            tout_chain_reg <= 1'h0;
        end else begin
            tout_pin_reg <= (TRIG_OUT_MODE == ela_pkg::TOUT_PIN) ? tout_level : 1'h0;
            tout_chain_reg <= (TRIG_OUT_MODE == ela_pkg::TOUT_CHAIN) ? tout_level : 1'h0;
        end
    end

    logic busy_reg;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'h0;
        end else begin
            busy_reg <= state_next == ela_pkg::ST_FILL || state_next == ela_pkg::ST_WAIT
                || state_next == ela_pkg::ST_POST;
        end
    end

    assign trig_out_pin = tout_pin_reg;
    assign chain_trig_out = tout_chain_reg;
    assign capture_busy = busy_reg;
    assign triggered = hit_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_fire_post;
        fire && post_cfg_reg != '0;
    endsequence
    sequence s_quiet_wait;
        in_wait && !arm_pulse && !ext_act;
    endsequence

    post_load_a: assert property (s_fire_post |=> state_reg == ela_pkg::ST_POST
        && post_left_reg == $past(post_cfg_reg))
        else $error("post phase not loaded with post count");
    post_end_a: assert property (state_reg == ela_pkg::ST_POST && post_left_reg == AW'(1)
        && !arm_pulse |=> state_reg == ela_pkg::ST_DONE && !wr_en)
        else $error("capture did not stop after post samples");
    wr_wrap_a: assert property (wr_en |=> wr_ptr_reg == $past(wr_ptr_reg) + 1'h1)
        else $error("write pointer failed to advance");
    done_hold_a: assert property (state_reg == ela_pkg::ST_DONE && !repeat_eff
        && !arm_pulse |=> state_reg == ela_pkg::ST_DONE)
        else $error("one-shot capture left done");
    ext_trig_a: assert property (ext_act |-> $past(trig_in_pin, 2) == trig_in_pol)
        else $error("external trigger level mismatch");
    cond_both_a: assert property (s_quiet_wait and (cond_sel == ela_pkg::COND_AB
        && !(ev_a && ev_b)) |=> in_wait)
        else $error("both-event trigger fired early");
    seq_order_a: assert property (cond_sel == ela_pkg::COND_B_THEN_A && $rose(ev_a)
        |-> $past(ev_b))
        else $error("first event counted before second");
    trig_out_a: assert property (fire && TRIG_OUT_MODE == ela_pkg::TOUT_PIN
        |=> trig_out_pin == $past(trig_out_pol) [*2])
        else $error("trigger output not at active level");
    preset_a: assert property (arm_pulse && pos_sel == ela_pkg::POS_CENTER
        |=> post_cfg_reg == ela_pkg::POST_CENTER)
        else $error("center preset not applied");
    read_ack_a: assert property (rd_pulse |=> ack_tgl_reg != $past(ack_tgl_reg))
        else $error("read request not acknowledged");
endmodule

// ---- tb/host_link_model.sv ----
// Purpose: host side of the trace readout link
// Assumes: pins change 1 ns after link_clk rises
// Notes: words arrive LSB first on link_tdo
`timescale 1ns/1ns
module host_link_model (
    input wire logic link_clk,
    input wire logic link_word_ready,
    input wire logic link_tdo,
    output logic link_arm,
    output logic link_load,
    output logic link_shift
);
    initial {link_arm, link_load, link_shift} = 3'h0;
    task automatic arm();
        @(posedge link_clk) #1 link_arm = 1'b1;
        @(posedge link_clk) #1 link_arm = 1'b0;
    endtask
    task automatic read_word(output logic [15:0] w);
        int n;
        n = 0;
        @(posedge link_clk) #1 link_load = 1'b1;
        @(posedge link_clk) #1 link_load = 1'b0;
        // bounded wait: a lost word shows up as a bad compare, not a hang
        do begin
            @(posedge link_clk) #1;
            n++;
        end while (link_word_ready !== 1'b1 && n < 30);
        link_shift = 1'b1;
        for (int i = 0; i < 16; i++) begin
            w[i] = link_tdo;
            @(posedge link_clk) #1;
        end
        link_shift = 1'b0;
    endtask
endmodule

// ---- tb/ela_core_tb_top.sv ----
// Purpose: self-checking bench for the trigger analyzer core
// Assumes: inputs move 1 ns after the clock edge
// Notes: model follows trigger bit 0 (edge) and bit 8 (level)
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module ela_core_tb_top;
    localparam int W = ela_pkg::TRIG_W;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic [W-1:0] trig_bus = '0;
    logic [ela_pkg::TRACE_W-1:0] trace_bus = '0;
    logic trig_in_pin = 1'b1;
    logic trig_in_en = 1'b0;
    logic trig_in_pol = 1'b0;
    logic trig_out_pol = 1'b0;
    logic [3*W-1:0] pat_a_code = '1;
    logic [3*W-1:0] pat_b_code = '1;
    logic [2:0] cmp_op_a = 3'h0;
    logic [ela_pkg::CNT_W-1:0] count_a = 16'h0001;
    logic [1:0] cond_sel = 2'h0;
    logic [1:0] pos_sel = ela_pkg::POS_POST;
    wire logic link_arm, link_load, link_shift, link_tdo, link_word_ready, link_done;
    wire logic trig_out_pin, chain_trig_out, capture_busy, triggered;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int n_a = 0;
    bit m_en, ev_a, ev_b, trg_m, trg_m1, p0, got;
    logic [15:0] last, tv, w, w0;
    // per case: pattern code of bit 0, compare op, count, condition
    logic [2:0] codes [11] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1};
    logic [2:0] ops [11] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
    logic [15:0] cnts [11] = '{16'h1, 16'h1, 16'h1, 16'h1, 16'h3, 16'h1, 16'h1, 16'h2,
        16'h1, 16'h1, 16'h1};
    logic [1:0] conds [11] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h3};
    always #10 ref_clk = ~ref_clk;
    always begin
        #7 link_clk = 1'b1;
        #8 link_clk = 1'b0;
    end
    always @(posedge ref_clk) #1 trace_bus++;
    ela_core uut (.ref_clk, .rst, .link_clk, .trig_bus, .trace_bus, .trig_in_pin, .trig_in_en,
        .trig_in_pol, .trig_out_pol, .pat_a_code, .pat_b_code, .cmp_op_a, .cmp_op_b(3'h0),
        .count_a, .count_b(16'h0001), .cond_sel, .pos_sel, .post_len(9'h000),
        .repeat_mode(1'b0), .link_arm, .link_load, .link_shift, .link_tdo, .link_word_ready,
        .link_done, .trig_out_pin, .chain_trig_out, .capture_busy, .triggered);
    host_link_model host (.link_clk, .link_word_ready, .link_tdo, .link_arm, .link_load,
        .link_shift);
    function automatic bit hit_a(logic [2:0] c, logic [2:0] op, bit x, bit p);
        if (c == ela_pkg::PAT_RISE) return x && !p;
        if (c == ela_pkg::PAT_FALL) return !x && p;
        if (c == ela_pkg::PAT_BOTH) return x != p;
        case (op)
            ela_pkg::CMP_NE: return x != c[0];
            ela_pkg::CMP_GT: return x > c[0];
            ela_pkg::CMP_LT: return x < c[0];
            ela_pkg::CMP_GE: return x >= c[0];
            default: return x == c[0];
        endcase
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    always @(posedge ref_clk) begin
        if (m_en) begin
            // one cycle of slack for the registered trigger flag
            `CHK(triggered === trg_m || triggered === trg_m1, 1'b1)
            if (triggered === 1'b1 && !got) begin
                tv = last;
                got = 1'b1;
            end
            trg_m1 = trg_m;
            trg_m = trg_m || (ev_a && (cond_sel != ela_pkg::COND_AB || ev_b));
            if (hit_a(pat_a_code[2:0], cmp_op_a, trig_bus[0], p0) &&
                    (cond_sel != ela_pkg::COND_B_THEN_A || ev_b))
                n_a++;
            ev_a = ev_a || n_a >= count_a;
            ev_b = ev_b || trig_bus[8];
        end
        p0 = trig_bus[0];
        last = trace_bus;
    end
    task automatic run_case(logic [2:0] code, logic [2:0] op, logic [15:0] n, logic [1:0] cond);
        logic [31:0] r;
        pat_a_code[2:0] = code;
        cmp_op_a = op;
        count_a = n;
        cond_sel = cond;
        trig_out_pol = ~trig_out_pol;
        trig_bus = '0;
        // park bit 0 where it cannot match while the pre-trigger part fills
        trig_bus[0] = hit_a(code, op, 1'b0, 1'b0);
        host.arm();
        repeat (10) @(posedge ref_clk) #1;
        `CHK(capture_busy, 1'b1)
        repeat (590) @(posedge ref_clk) #1;
        `CHK(trig_out_pin, ~trig_out_pol)
        n_a = 0;
        {ev_a, ev_b, trg_m, trg_m1, got} = 5'h00;
        m_en = 1'b1;
        repeat (60) begin
            r = $urandom;
            trig_bus = r[W-1:0];
            trig_bus[8] = r[31:30] == 2'h0;
            @(posedge ref_clk) #1;
        end
        m_en = 1'b0;
        `CHK(chain_trig_out, 1'b0)
        if (trg_m1) `CHK(trig_out_pin, trig_out_pol)
    endtask
    task automatic read_back();
        int n;
        int pre;
        n = 0;
        pre = ela_pkg::DEPTH - 1 - ela_pkg::DEPTH * 5 / 100;
        while (link_done !== 1'b1 && n < 400) begin
            @(posedge link_clk) #1;
            n++;
        end
        `CHK(link_done, 1'b1)
        for (int k = 0; k < ela_pkg::DEPTH; k++) begin
            host.read_word(w);
            if (k == 0) w0 = w;
            `CHK(w, w0 + 16'(k))
            if (k == pre) `CHK(w, tv)
        end
    endtask
    initial begin
        pat_b_code[26:24] = ela_pkg::PAT_ONE;
        void'($urandom(55));
        #15;
        `CHK({capture_busy, triggered, trig_out_pin, link_done}, 4'h0)
        repeat (2) @(posedge ref_clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 11; i++) begin
            // read-back case keeps the post preset; others walk all positions
            pos_sel = (i == 0) ? ela_pkg::POS_POST : 2'(i % 4);
            run_case(codes[i], ops[i], cnts[i], conds[i]);
            if (i == 0) read_back();
            $display("test %0d done", i);
        end
        trig_in_en = 1'b1;
        pat_a_code[2:0] = ela_pkg::PAT_RISE;
        // a leftover magnitude op matches an all don't-care bus at once
        cmp_op_a = ela_pkg::CMP_EQ;
        trig_bus = '0;
        host.arm();
        repeat (620) @(posedge ref_clk) #1;
        `CHK(triggered, 1'b0)
        trig_in_pin = 1'b0;
        repeat (8) @(posedge ref_clk) #1;
        `CHK(triggered, 1'b1)
        $display("test ext done");
        tally_and_finish();
    end
endmodule
